// File: rtl/aeqsc_top.sv
// Adaptive equalization status register, strap sampling and two-wire target.
// Assumes SCL/SDA and straps arrive asynchronously; SDA is open drain outside.
`timescale 1ns/100ps
`default_nettype none
module aeqsc_top import aeqsc_pkg::*; #(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_reset,
    // Two-wire bus
    input  wire logic                    i_scl,
    input  wire logic                    i_sda,
    output logic                         o_sda_out,
    output logic                         o_sda_oe,
    // Straps
    input  wire logic [1:0]              i_cfg_select_strap,
    input  wire logic [1:0]              i_address_bit1_strap,
    input  wire logic [1:0]              i_address_bit0_strap,
    input  wire logic [1:0]              i_eq_strap,
    // Analog front end
    input  wire logic [7:0]              i_eye_metric,
    input  wire logic                    i_long_channel,
    // Equalizer settings and status
    output logic                         o_twowire_mode,
    output logic [NUM_INPUTS-1:0][3:0]   o_eq_setting,
    output logic [3:0]                   o_eq_result_code,
    output logic                         o_eq_done
);
    typedef enum logic [2:0] {
        I2C_IDLE = 3'b000,
        I2C_ADDR = 3'b001,
        I2C_AACK = 3'b010,
        I2C_WR   = 3'b011,
        I2C_WACK = 3'b100,
        I2C_RD   = 3'b101,
        I2C_RACK = 3'b110
    } aeqsc_i2c_t;

    function automatic logic [6:0] strap_index(input logic [1:0] lvl);
        case (lvl)
            STRAP_LOW:  strap_index = 7'h01;
            STRAP_HIGH: strap_index = 7'h02;
            default:    strap_index = 7'h00;
        endcase
    endfunction

    // Pin synchroniser: the first stage feeds only the second
    logic [9:0] pins, s1, s2, s3, filt, next_filt;
    logic       scl_f, sda_f, scl_p, sda_p;
    logic [1:0] cfg_lvl, a1_lvl, a0_lvl, eq_lvl;
    assign pins = {i_scl, i_sda, i_cfg_select_strap, i_address_bit1_strap,
                   i_address_bit0_strap, i_eq_strap};
    assign next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
    assign {scl_f, sda_f, cfg_lvl, a1_lvl, a0_lvl, eq_lvl} = filt;

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            s1    <= SYNC_RST;
            s2    <= SYNC_RST;
            s3    <= SYNC_RST;
            filt  <= SYNC_RST;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            s1    <= pins;
            s2    <= s1;
            s3    <= s2;
            filt  <= next_filt;
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    // Strap capture and equalizer outputs
    logic [2:0]                  strap_cnt, next_strap_cnt;
    logic                        strap_done, next_strap_done;
    logic                        twowire, next_twowire;
    logic [6:0]                  my_addr, next_addr;
    logic [3:0]                  pin_eq, next_pin_eq;
    logic [NUM_INPUTS-1:0][3:0]  eq_out, next_eq_out;
    logic [NUM_INPUTS-1:0][3:0]  eq_reg, next_eq_reg;
    logic [3:0]                  ctrl, next_ctrl;
    logic [3:0]                  ovr, next_ovr;
    logic [3:0]                  short_code, next_short;
    logic [3:0]                  long_code, next_long;
    logic [3:0]                  eng_applied, eng_result;
    logic                        eng_done;
    logic                        start_run, next_start_run;

    always_comb begin
        next_strap_cnt  = strap_cnt;
        next_strap_done = strap_done;
        next_twowire    = twowire;
        next_addr       = my_addr;
        next_pin_eq     = pin_eq;
        if (!strap_done) begin
            if (strap_cnt == STRAP_WAIT) begin
                next_strap_done = 1'b1;
                next_twowire    = cfg_lvl != STRAP_LOW;
                next_addr       = 7'(TARGET_ADDR_BASE + ADDR_STEP * strap_index(a1_lvl)
                                  + strap_index(a0_lvl));
                next_pin_eq     = {eq_lvl, 2'b00};
            end else begin
                next_strap_cnt = strap_cnt + 3'h1;
            end
        end
        for (int k = 0; k < NUM_INPUTS; k++) begin
            if (!twowire) begin
                next_eq_out[k] = pin_eq;
            end else if (k == 0 && ctrl[1:0] != EN_OFF) begin
                next_eq_out[k] = eng_applied;
            end else begin
                next_eq_out[k] = eq_reg[k];
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            strap_cnt  <= 3'h0;
            strap_done <= 1'b0;
            twowire    <= 1'b0;
            my_addr    <= TARGET_ADDR_BASE;
            pin_eq     <= CODE_RST;
            eq_out     <= '0;
        end else begin
            strap_cnt  <= next_strap_cnt;
            strap_done <= next_strap_done;
            twowire    <= next_twowire;
            my_addr    <= next_addr;
            pin_eq     <= next_pin_eq;
            eq_out     <= next_eq_out;
        end
    end

    // Two-wire target; the bus is only answered in two-wire mode
    aeqsc_i2c_t i2c, next_i2c;
    logic [7:0] sh, next_sh, ptr, next_ptr, rdata, wr_data;
    logic [2:0] bitcnt, next_bitcnt, eq_idx;
    logic       first, next_first, rw, next_rw, oe, next_oe, ph, next_ph;
    logic       wr_en, rd_load, active, scl_rise, scl_fall, start_c, stop_c, in_eq;
    assign active   = strap_done && twowire;
    assign scl_rise = scl_f && !scl_p;
    assign scl_fall = !scl_f && scl_p;
    assign start_c  = scl_f && scl_p && sda_p && !sda_f;
    assign stop_c   = scl_f && scl_p && !sda_p && sda_f;
    assign wr_data  = {sh[6:0], sda_f};
    assign in_eq    = ptr >= ADDR_EQ0 && ptr < ADDR_EQ0 + 8'(NUM_INPUTS);
    assign eq_idx   = 3'(ptr - ADDR_EQ0);

    always_comb begin
        rdata = 8'h00;
        case (ptr)
            ADDR_RESULT: rdata = {3'h0, eng_done, eng_result};
            ADDR_CTRL:   rdata = {4'h0, ctrl};
            ADDR_OVR:    rdata = {4'h0, ovr};
            ADDR_SHORT:  rdata = {4'h0, short_code};
            ADDR_LONG:   rdata = {4'h0, long_code};
            default:     rdata = in_eq ? {4'h0, eq_reg[eq_idx]} : 8'h00;
        endcase
    end

    always_comb begin
        next_i2c    = i2c;
        next_sh     = sh;
        next_bitcnt = bitcnt;
        next_ptr    = ptr;
        next_first  = first;
        next_rw     = rw;
        next_oe     = oe;
        next_ph     = ph;
        wr_en       = 1'b0;
        rd_load     = 1'b0;
        case (i2c)
            I2C_ADDR, I2C_WR: begin
                if (scl_rise) begin
                    next_sh     = wr_data;
                    next_bitcnt = bitcnt + 3'h1;
                    next_ph     = 1'b0;
                    if (bitcnt == 3'h7 && i2c == I2C_ADDR) begin
                        next_rw  = sda_f;
                        next_i2c = (sh[6:0] == my_addr) ? I2C_AACK : I2C_IDLE;
                    end else if (bitcnt == 3'h7) begin
                        next_i2c   = I2C_WACK;
                        next_first = 1'b0;
                        next_ptr   = first ? wr_data : ptr + 8'h01;
                        wr_en      = !first;
                    end
                end
            end
            I2C_AACK, I2C_WACK: begin
                if (scl_fall) begin
                    next_ph     = !ph;
                    next_oe     = !ph;
                    next_bitcnt = 3'h0;
                    if (ph && i2c == I2C_AACK && rw) begin
                        rd_load  = 1'b1;
                        next_sh  = rdata;
                        next_oe  = !rdata[7];
                        next_ptr = ptr + 8'h01;
                        next_i2c = I2C_RD;
                    end else if (ph) begin
                        next_i2c = I2C_WR;
                    end
                end
            end
            I2C_RD: begin
                if (scl_fall) begin
                    next_sh = {sh[6:0], 1'b0};
                    next_oe = !sh[6];
                end
                if (scl_rise) begin
                    next_bitcnt = bitcnt + 3'h1;
                    next_ph     = 1'b0;
                    next_i2c    = (bitcnt == 3'h7) ? I2C_RACK : I2C_RD;
                end
            end
            I2C_RACK: begin
                if (scl_fall && !ph) begin
                    next_oe = 1'b0;
                    next_ph = 1'b1;
                end else if (scl_rise && ph && sda_f) begin
                    next_i2c = I2C_IDLE;
                end else if (scl_fall) begin
                    rd_load     = 1'b1;
                    next_sh     = rdata;
                    next_oe     = !rdata[7];
                    next_ptr    = ptr + 8'h01;
                    next_bitcnt = 3'h0;
                    next_ph     = 1'b0;
                    next_i2c    = I2C_RD;
                end
            end
            default: begin
                next_oe = 1'b0;
            end
        endcase
        if (start_c && active) begin
            next_i2c    = I2C_ADDR;
            next_bitcnt = 3'h0;
            next_oe     = 1'b0;
            next_first  = 1'b1;
        end
        if (stop_c || !active) begin
            next_i2c = I2C_IDLE;
            next_oe  = 1'b0;
        end
    end

    // Register writes; the status register at its offset takes no write
    always_comb begin
        next_ctrl   = ctrl;
        next_ovr    = ovr;
        next_short  = short_code;
        next_long   = long_code;
        next_eq_reg = eq_reg;
        next_start_run = wr_en && ptr == ADDR_CTRL;
        if (wr_en) begin
            case (ptr)
                ADDR_CTRL:  next_ctrl  = wr_data[3:0];
                ADDR_OVR:   next_ovr   = wr_data[3:0];
                ADDR_SHORT: next_short = wr_data[3:0];
                ADDR_LONG:  next_long  = wr_data[3:0];
                default: begin
                    if (in_eq) begin
                        next_eq_reg[eq_idx] = wr_data[3:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            i2c        <= I2C_IDLE;
            sh         <= 8'h00;
            ptr        <= 8'h00;
            bitcnt     <= 3'h0;
            first      <= 1'b1;
            rw         <= 1'b0;
            oe         <= 1'b0;
            ph         <= 1'b0;
            ctrl       <= CTRL_RST;
            ovr        <= CODE_RST;
            short_code <= CODE_RST;
            long_code  <= CODE_RST;
            eq_reg     <= '0;
            start_run  <= 1'b0;
        end else begin
            i2c        <= next_i2c;
            sh         <= next_sh;
            ptr        <= next_ptr;
            bitcnt     <= next_bitcnt;
            first      <= next_first;
            rw         <= next_rw;
            oe         <= next_oe;
            ph         <= next_ph;
            ctrl       <= next_ctrl;
            ovr        <= next_ovr;
            short_code <= next_short;
            long_code  <= next_long;
            eq_reg     <= next_eq_reg;
            start_run  <= next_start_run;
        end
    end

    // A control write starts a run one clock later, once the new settings stand
    aeqsc_engine #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_engine (
        .i_sys_clk       (i_sys_clk),
        .i_reset         (i_reset),
        .i_start         (start_run),
        .i_enable        (ctrl[1:0]),
        .i_type_select   (ctrl[CTRL_TYPE_BIT]),
        .i_override_en   (ctrl[CTRL_OVR_BIT]),
        .i_override_code (ovr),
        .i_short_code    (short_code),
        .i_long_code     (long_code),
        .i_eye_metric    (i_eye_metric),
        .i_long_channel  (i_long_channel),
        .o_applied_code  (eng_applied),
        .o_result_code   (eng_result),
        .o_done          (eng_done)
    );

    assign o_sda_out        = 1'b0;
    assign o_sda_oe         = oe;
    assign o_twowire_mode   = twowire;
    assign o_eq_setting     = eq_out;
    assign o_eq_result_code = eng_result;
    assign o_eq_done        = eng_done;

    addr_float_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (!strap_done && strap_cnt == STRAP_WAIT && a1_lvl == STRAP_FLOAT
         && a0_lvl == STRAP_FLOAT) |=> my_addr == TARGET_ADDR_BASE)
        else $error("floating straps did not give default address");
    mode_sel_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (!strap_done && strap_cnt == STRAP_WAIT)
        |=> o_twowire_mode == ($past(cfg_lvl) != STRAP_LOW))
        else $error("config mode does not follow strap");
    pin_eq_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (strap_done && !twowire) ##1 (strap_done && !twowire)
        |=> o_eq_setting == {NUM_INPUTS{$past(pin_eq, 2)}})
        else $error("pin mode settings do not follow straps");
    result_read_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (rd_load && ptr == ADDR_RESULT)
        |=> sh == {3'h0, $past(eng_done), $past(eng_result)})
        else $error("status register read value wrong");
endmodule
`default_nettype wire

// File: rtl/aeqsc_pkg.sv
// Constants for the adaptive equalization status and two-wire config block.
// Assumes a single 40 MHz system clock.
package aeqsc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_RESULT = 8'h3b;
    localparam logic [7:0] ADDR_CTRL   = 8'h40;
    localparam logic [7:0] ADDR_OVR    = 8'h41;
    localparam logic [7:0] ADDR_SHORT  = 8'h42;
    localparam logic [7:0] ADDR_LONG   = 8'h43;
    localparam logic [7:0] ADDR_EQ0    = 8'h50;
    // Reset values
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [3:0] CTRL_RST   = 4'h0;
    localparam logic [3:0] CODE_RST   = 4'h0;
    localparam logic [9:0] SYNC_RST   = 10'h300;
    // Fields
    localparam int DONE_BIT      = 4;
    localparam int CTRL_TYPE_BIT = 2;
    localparam int CTRL_OVR_BIT  = 3;
    localparam int NUM_INPUTS    = 7;
    localparam logic [3:0] CODE_LAST = 4'hf;
    localparam logic [1:0] EN_OFF    = 2'h0;
    localparam logic [1:0] EN_FULL_A = 2'h1;
    localparam logic [1:0] EN_FULL_B = 2'h3;
    localparam logic [1:0] EN_FAST   = 2'h1;
    // Two-wire target address with both address straps floating
    localparam logic [6:0] TARGET_ADDR_BASE = 7'h12;
    localparam logic [6:0] ADDR_STEP        = 7'h03;
    // Timing
    localparam int SETTLE_NS     = 1000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] STRAP_WAIT = 3'h4;
    // Three-level strap pin encoding
    typedef enum logic [1:0] {
        STRAP_LOW   = 2'b00,
        STRAP_HIGH  = 2'b01,
        STRAP_FLOAT = 2'b10
    } aeqsc_strap_t;
endpackage

// File: rtl/aeqsc_engine.sv
// Adaptive equalization run control: full search and fast short/long pick.
// Assumes eye metric and channel class come from analog logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module aeqsc_engine import aeqsc_pkg::*; #(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset,
    // Run control
    input  wire logic       i_start,
    input  wire logic [1:0] i_enable,
    input  wire logic       i_type_select,
    input  wire logic       i_override_en,
    input  wire logic [3:0] i_override_code,
    input  wire logic [3:0] i_short_code,
    input  wire logic [3:0] i_long_code,
    // Analog front end
    input  wire logic [7:0] i_eye_metric,
    input  wire logic       i_long_channel,
    // Results
    output logic [3:0]      o_applied_code,
    output logic [3:0]      o_result_code,
    output logic            o_done
);
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_FULL = 2'b01,
        ENG_FAST = 2'b10
    } aeqsc_eng_t;
    localparam logic [15:0] SETTLE_LOAD = 16'(SETTLE_CYCLES - 1);

    aeqsc_eng_t  state, next_state;
    logic [15:0] timer, next_timer;
    logic [3:0]  trial, next_trial;
    logic [3:0]  best, next_best;
    logic [3:0]  result, next_result;
    logic [7:0]  best_metric, next_best_metric;
    logic        done, next_done;
    logic        run_full, run_fast, expired, better;
    logic [3:0]  pick;

    assign run_full = i_type_select && (i_enable == EN_FULL_A || i_enable == EN_FULL_B);
    assign run_fast = !i_type_select && i_enable == EN_FAST;
    assign expired  = timer == 16'h0000;
    assign better   = trial == 4'h0 || i_eye_metric > best_metric;
    assign pick     = better ? trial : best;

    always_comb begin
        next_state       = state;
        next_timer       = timer;
        next_trial       = trial;
        next_best        = best;
        next_best_metric = best_metric;
        next_result      = result;
        next_done        = done;
        case (state)
            ENG_FULL: begin
                if (expired) begin
                    if (better) begin
                        next_best        = trial;
                        next_best_metric = i_eye_metric;
                    end
                    if (trial == CODE_LAST) begin
                        next_result = pick;
                        next_done   = 1'b1;
                        next_state  = ENG_IDLE;
                    end else begin
                        next_trial = trial + 4'h1;
                        next_timer = SETTLE_LOAD;
                    end
                end else begin
                    next_timer = timer - 16'h0001;
                end
            end
            ENG_FAST: begin
                if (expired) begin
                    next_result = i_long_channel ? i_long_code : i_short_code;
                    next_done   = 1'b1;
                    next_state  = ENG_IDLE;
                end else begin
                    next_timer = timer - 16'h0001;
                end
            end
            default: begin
                next_state = ENG_IDLE;
            end
        endcase
        // A restart abandons the old run and keeps done clear; a result it completes in the same cycle is still stored
        if (i_start && (run_full || run_fast)) begin
            next_state       = run_full ? ENG_FULL : ENG_FAST;
            next_timer       = SETTLE_LOAD;
            next_trial       = 4'h0;
            next_best        = 4'h0;
            next_best_metric = 8'h00;
            next_done        = 1'b0;
        end
        if (i_override_en) begin
            next_result = i_override_code;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state       <= ENG_IDLE;
            timer       <= 16'h0000;
            trial       <= 4'h0;
            best        <= 4'h0;
            best_metric <= 8'h00;
            result      <= RESULT_RST[3:0];
            done        <= RESULT_RST[DONE_BIT];
        end else begin
            state       <= next_state;
            timer       <= next_timer;
            trial       <= next_trial;
            best        <= next_best;
            best_metric <= next_best_metric;
            result      <= next_result;
            done        <= next_done;
        end
    end

    // Fast mode drives the short setting until the channel is classified
    assign o_applied_code = (state == ENG_FULL) ? trial :
                            (state == ENG_FAST) ? i_short_code : result;
    assign o_result_code  = result;
    assign o_done         = done;

    done_set_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state == ENG_FULL && expired && trial == CODE_LAST && !i_start) |=> o_done)
        else $error("done flag not set after final settle");
    full_pick_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state == ENG_FULL && expired && trial == CODE_LAST && !i_override_en)
        |=> o_result_code == $past(pick))
        else $error("full search result is not the best code");
    fast_pick_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (state == ENG_FAST && expired && !i_start && !i_override_en)
        |=> o_result_code == ($past(i_long_channel) ? $past(i_long_code) : $past(i_short_code)))
        else $error("fast result does not match channel class");
    ovr_show_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_override_en |=> o_result_code == $past(i_override_code))
        else $error("override value not reflected");
    restart_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        (i_start && (run_full || run_fast)) |=> !o_done [*2])
        else $error("done flag not cleared by new run");
endmodule
`default_nettype wire

// File: test/aeqsc_host_model.sv
// Two-wire bus host model: drives SCL and pulls SDA low, bit by bit.
// Assumes the bench resolves SDA with a pull-up from all pull-down enables.
`timescale 1ns/100ps
`default_nettype none
module aeqsc_host_model (
    // Clock
    input  wire logic i_sys_clk,
    // Bus pins
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic hc(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    // Serves first and repeated start; SDA waits after SCL falls for filter skew
    task automatic start();
        hc(2);
        o_sda_low = 1'b0;
        hc(6);
        o_scl = 1'b1;
        hc(8);
        o_sda_low = 1'b1;
        hc(8);
        o_scl = 1'b0;
    endtask
    task automatic stop();
        hc(2);
        o_sda_low = 1'b1;
        hc(6);
        o_scl = 1'b1;
        hc(8);
        o_sda_low = 1'b0;
        hc(8);
    endtask
    task automatic bitx(input logic b, output logic s);
        hc(2);
        o_sda_low = ~b;
        hc(6);
        o_scl = 1'b1;
        hc(4);
        s = i_sda;
        hc(4);
        o_scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            bitx(tx[i], rx[i]);
        end
        bitx(ack_in, ack_out);
    endtask
endmodule
`default_nettype wire

// File: test/test_aeqsc_top.sv
// Self-checking bench for the equalization status block over two-wire.
// Assumes the equalization strap is driven high; other straps are set per reset.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module test_aeqsc_top import aeqsc_pkg::*; ;
    logic                      clk, rst, scl, h_low, lc, oe, so, tw, done, a;
    wire                       sda;
    logic [3:0]                res;
    logic [1:0]                cfg_s, a1_s, a0_s;
    logic [7:0]                v;
    logic [NUM_INPUTS-1:0][3:0] eqs;
    int                        err_count = 0;
    int                        comparisons = 0;
    assign sda = ~(h_low | oe);
    aeqsc_host_model h (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(h_low));
    aeqsc_top #(.SETTLE_CYCLES(4)) i_dut (.i_sys_clk(clk), .i_reset(rst), .i_scl(scl),
        .i_sda(sda), .o_sda_out(so), .o_sda_oe(oe), .i_cfg_select_strap(cfg_s),
        .i_address_bit1_strap(a1_s), .i_address_bit0_strap(a0_s), .i_eq_strap(2'b01),
        .i_eye_metric({4'h0, eqs[0]}), .i_long_channel(lc), .o_twowire_mode(tw),
        .o_eq_setting(eqs), .o_eq_result_code(res), .o_eq_done(done));
    task automatic conclude();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        logic [7:0] x;
        logic       k;
        h.start();
        h.xfer(8'h24, 1'b1, x, k);
        h.xfer(off, 1'b1, x, k);
        h.xfer(d, 1'b1, x, k);
        h.stop();
    endtask
    // Master NACKs the single read byte so the target lets go of SDA
    task automatic rd(input logic [6:0] ad, input logic [7:0] off,
                      output logic [7:0] d, output logic k);
        logic [7:0] x;
        logic       j;
        h.start();
        h.xfer({ad, 1'b0}, 1'b1, x, k);
        h.xfer(off, 1'b1, x, j);
        h.start();
        h.xfer({ad, 1'b1}, 1'b1, x, j);
        h.xfer(8'hff, 1'b1, d, j);
        h.stop();
    endtask
    // Straps change only under reset; the bus must be idle when this is called
    task automatic reboot(input logic [1:0] c, input logic [1:0] b1, input logic [1:0] b0);
        rst = 1'b1;
        cfg_s = c;
        a1_s = b1;
        a0_s = b0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Whole run is under ten thousand cycles of bus traffic
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        lc = 1'b0;
        reboot(2'b10, 2'b10, 2'b10);
        `CHK("mode", 1'b1, tw)
        `CHK("sda out", 1'b0, so)
        rd(7'h12, ADDR_RESULT, v, a);
        `CHK("ack", 1'b0, a)
        `CHK("status", RESULT_RST, v)
        rd(7'h13, ADDR_RESULT, v, a);
        `CHK("other ack", 1'b1, a)
        wr(ADDR_RESULT, 8'hff);
        rd(7'h12, ADDR_RESULT, v, a);
        `CHK("read only", 8'h00, v)
        `CHK("eq1 strap", 4'h0, eqs[1])
        wr(ADDR_EQ0 + 8'h01, 8'h07);
        `CHK("eq1", 4'h7, eqs[1])
        `CHK("eq2", 4'h0, eqs[2])
        wr(ADDR_SHORT, 8'h05);
        wr(ADDR_LONG, 8'h0a);
        lc = 1'b1;
        wr(ADDR_CTRL, 8'h01);
        rd(7'h12, ADDR_RESULT, v, a);
        `CHK("fast", 8'h1a, v)
        wr(ADDR_CTRL, 8'h05);
        `CHK("done clear", 1'b0, done)
        repeat (80) @(negedge clk);
        `CHK("full", 5'h1f, {done, res})
        wr(ADDR_OVR, 8'h09);
        wr(ADDR_CTRL, 8'h08);
        `CHK("override", 4'h9, res)
        lc = 1'b0;
        wr(ADDR_CTRL, 8'h01);
        `CHK("short", 5'h15, {done, res})
        wr(ADDR_CTRL, 8'h07);
        `CHK("full b run", 5'h05, {done, res})
        repeat (80) @(negedge clk);
        `CHK("full b", 5'h1f, {done, res})
        reboot(2'b01, 2'b00, 2'b01);
        `CHK("mode high", 1'b1, tw)
        rd(7'h17, ADDR_RESULT, v, a);
        `CHK("strap ack", 1'b0, a)
        `CHK("reset status", RESULT_RST, v)
        reboot(2'b00, 2'b10, 2'b10);
        `CHK("pin mode", 1'b0, tw)
        `CHK("pin eq", {NUM_INPUTS{4'h4}}, eqs)
        rd(7'h12, ADDR_RESULT, v, a);
        `CHK("pin ignore", 1'b1, a)
        conclude();
    end
endmodule
`default_nettype wire
